// ==== inc/sbp_consts.svh ====
// Constants for the six-bit I/O port with peripheral overrides.
// Assumes inclusion by the port package and design files by bare name.
`ifndef SBP_CONSTS_SVH
`define SBP_CONSTS_SVH

// ****************************************
// Widths and positions
// ****************************************
`define SBP_PINS        6
`define SBP_DRV_PINS    5
`define SBP_REG_W       8
`define SBP_PIN_RESET   5

// ****************************************
// Reset values
// ****************************************
`define SBP_DIR_RST     5'h1F
`define SBP_LAT_RST     5'h00

`endif

// ==== inc/sbp_pkg.sv ====
// Types shared by the six-bit I/O port files.
// Assumes sbp_consts.svh is on the include path.
`include "sbp_consts.svh"

package sbp_pkg;

	typedef logic [`SBP_DRV_PINS-1:0] sbp_drv_t;
	typedef logic [`SBP_REG_W-1:0]    sbp_byte_t;

	// Which source owns a driven pin
	typedef enum logic [2:0] {
		SBP_SRC_LATCH = 3'h1,
		SBP_SRC_LOW   = 3'h2,
		SBP_SRC_HIGH  = 3'h4
	} sbp_src_e;

endpackage

// ==== rtl/sbp_pin_mux.sv ====
// One driven port pin: peripheral override over latch under direction control.
// Assumes all inputs synchronous to the system clock; purely combinational.
`include "sbp_consts.svh"

module sbp_pin_mux
	import sbp_pkg::*;
(
	// Port state
	input  wire logic dir_i,
	input  wire logic lat_i,
	// Primary peripheral output (highest priority)
	input  wire logic hi_en_i,
	input  wire logic hi_val_i,
	input  wire logic hi_force_out_i,
	// Secondary peripheral output
	input  wire logic lo_en_i,
	input  wire logic lo_val_i,
	input  wire logic lo_tri_i,
	// Pin drive, enable low while driving
	output logic      pin_o,
	output logic      pin_oe_n_o
);

	always_comb begin
		pin_o      = lat_i;
		pin_oe_n_o = dir_i;
		if (hi_en_i && (!dir_i || hi_force_out_i)) begin
			pin_o      = hi_val_i;
			pin_oe_n_o = 1'b0;
		end else if (lo_en_i && !dir_i) begin
			pin_o      = lo_val_i;
			pin_oe_n_o = lo_tri_i;
		end
	end

endmodule

// ==== rtl/sbp_master_clear_input.sv ====
// Pin 5 selector: port input or external master-clear, by configuration bit.
// Assumes the pin level is synchronous to the system clock.
`include "sbp_consts.svh"

module sbp_master_clear_input
	import sbp_pkg::*;
(
	// Configuration and pin
	input  wire logic reset_pin_config_bit_i,
	input  wire logic pin5_i,
	// Results
	output logic      port_bit_o,
	output logic      master_clear_n_o
);

	assign port_bit_o       = reset_pin_config_bit_i ? 1'b0 : pin5_i;
	assign master_clear_n_o = reset_pin_config_bit_i ? pin5_i : 1'b1;

endmodule

// ==== rtl/sbp_port.sv ====
// Six-bit port, pins 0-4 bidirectional and pin 5 input-only, with direction, latch and peripheral overrides.
// Assumes a single 25 MHz clock, active-high asynchronous reset, plain ports.
`include "sbp_consts.svh"

module sbp_port
	import sbp_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	// Register access
	input  wire logic      port_wr_i,
	input  wire logic      latch_wr_i,
	input  wire logic      dir_wr_i,
	input  wire sbp_byte_t wdata_i,
	output sbp_byte_t      port_pin_register_o,
	output sbp_byte_t      output_latch_register_o,
	output sbp_byte_t      direction_register_o,
	// Configuration
	input  wire logic      reset_pin_config_bit_i,
	output logic           master_clear_input_n_o,
	// Pins: input level, output value, output enable (low drives)
	input  wire logic [5:0] pin_i,
	output logic [4:0]     pin_o,
	output logic [4:0]     pin_oe_n_o,
	// Unit 3 on pin 0 (compare/PWM and enhanced channel A)
	input  wire logic      capture_compare_unit_3_io_out_en_i,
	input  wire logic      capture_compare_unit_3_io_out_i,
	input  wire logic      pwm3a_en_i,
	input  wire logic      pwm3a_out_i,
	input  wire logic      pwm3a_tri_i,
	output logic           capture_compare_unit_3_io_capture_o,
	// Serial transceiver on pins 1 and 2
	input  wire logic      ser_tx_en_i,
	input  wire logic      ser_tx_i,
	input  wire logic      ser_sync_i,
	input  wire logic      ser_ck_out_i,
	input  wire logic      ser_dt_drive_i,
	input  wire logic      ser_dt_out_i,
	output logic           ser_ck_in_o,
	output logic           ser_rx_o,
	// Unit 4 and enhanced channel D on pin 3
	input  wire logic      capture_compare_unit_4_io_out_en_i,
	input  wire logic      capture_compare_unit_4_io_out_i,
	input  wire logic      pwm3d_en_i,
	input  wire logic      pwm3d_out_i,
	input  wire logic      pwm3d_tri_i,
	output logic           capture_compare_unit_4_io_capture_o,
	// Unit 5 and unit 1 enhanced PWM on pin 4
	input  wire logic      capture_compare_unit_5_io_out_en_i,
	input  wire logic      capture_compare_unit_5_io_out_i,
	input  wire logic      pwm1d_en_i,
	input  wire logic      pwm1d_out_i,
	input  wire logic      pwm1d_tri_i,
	output logic           capture_compare_unit_5_io_capture_o
);

	// ****************************************
	// Storage
	// ****************************************
	sbp_drv_t dir_reg;
	sbp_drv_t lat_reg;
	logic     pin5_bit;

	// Peripheral overrides only touch the pin drivers, never this register,
	// so software read-modify-write of direction stays safe.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dir_reg <= `SBP_DIR_RST;
		end else if (dir_wr_i) begin
			dir_reg <= wdata_i[`SBP_DRV_PINS-1:0];
		end
	end

	// Port and latch writes both land in the latch; latch write wins a tie
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lat_reg <= `SBP_LAT_RST;
		end else if (latch_wr_i) begin
			lat_reg <= wdata_i[`SBP_DRV_PINS-1:0];
		end else if (port_wr_i) begin
			lat_reg <= wdata_i[`SBP_DRV_PINS-1:0];
		end
	end

	// ****************************************
	// Read-back
	// ****************************************
	assign output_latch_register_o = {3'h0, lat_reg};
	assign direction_register_o    = {3'h0, dir_reg};
	assign port_pin_register_o     = {2'h0, pin5_bit, pin_i[4:0]};

	// ****************************************
	// Pin 5
	// ****************************************
	sbp_master_clear_input u_master_clear_input (
		.reset_pin_config_bit_i (reset_pin_config_bit_i),
		.pin5_i                 (pin_i[`SBP_PIN_RESET]),
		.port_bit_o             (pin5_bit),
		.master_clear_n_o       (master_clear_input_n_o)
	);

	// ****************************************
	// Per-pin override selection
	// ****************************************
	logic [4:0] hi_en;
	logic [4:0] hi_val;
	logic [4:0] hi_force;
	logic [4:0] lo_en;
	logic [4:0] lo_val;
	logic [4:0] lo_tri;

	always_comb begin
		hi_en    = 5'h00;
		hi_val   = 5'h00;
		hi_force = 5'h00;
		lo_en    = 5'h00;
		lo_val   = 5'h00;
		lo_tri   = 5'h00;
		// Pin 0
		hi_en[0]  = capture_compare_unit_3_io_out_en_i;
		hi_val[0] = capture_compare_unit_3_io_out_i;
		lo_en[0]  = pwm3a_en_i;
		lo_val[0] = pwm3a_out_i;
		lo_tri[0] = pwm3a_tri_i;
		// Pin 1: sync clock or async transmit
		hi_en[1]  = ser_sync_i ? ser_tx_en_i : 1'b0;
		hi_val[1] = ser_ck_out_i;
		lo_en[1]  = ser_sync_i ? 1'b0 : ser_tx_en_i;
		lo_val[1] = ser_tx_i;
		// Pin 2: sync data drives even with direction held at one
		hi_en[2]    = ser_sync_i && ser_dt_drive_i;
		hi_val[2]   = ser_dt_out_i;
		hi_force[2] = 1'b1;
		// Pin 3
		hi_en[3]  = capture_compare_unit_4_io_out_en_i;
		hi_val[3] = capture_compare_unit_4_io_out_i;
		lo_en[3]  = pwm3d_en_i;
		lo_val[3] = pwm3d_out_i;
		lo_tri[3] = pwm3d_tri_i;
		// Pin 4
		hi_en[4]  = capture_compare_unit_5_io_out_en_i;
		hi_val[4] = capture_compare_unit_5_io_out_i;
		lo_en[4]  = pwm1d_en_i;
		lo_val[4] = pwm1d_out_i;
		lo_tri[4] = pwm1d_tri_i;
	end

	genvar g;
	generate
		for (g = 0; g < `SBP_DRV_PINS; g = g + 1) begin : g_pin
			sbp_pin_mux u_mux (
				.dir_i          (dir_reg[g]),
				.lat_i          (lat_reg[g]),
				.hi_en_i        (hi_en[g]),
				.hi_val_i       (hi_val[g]),
				.hi_force_out_i (hi_force[g]),
				.lo_en_i        (lo_en[g]),
				.lo_val_i       (lo_val[g]),
				.lo_tri_i       (lo_tri[g]),
				.pin_o          (pin_o[g]),
				.pin_oe_n_o     (pin_oe_n_o[g])
			);
		end
	endgenerate

	// ****************************************
	// Peripheral inputs
	// ****************************************
	// Gated by direction so only pin 2, when sync data forces it out, loops a driven level back as input data
	assign capture_compare_unit_3_io_capture_o = dir_reg[0] & pin_i[0];
	assign ser_ck_in_o    = dir_reg[1] & pin_i[1];
	assign ser_rx_o       = dir_reg[2] ? pin_i[2] : 1'b1;
	assign capture_compare_unit_4_io_capture_o = dir_reg[3] & pin_i[3];
	assign capture_compare_unit_5_io_capture_o = dir_reg[4] & pin_i[4];

	// ****************************************
	// Checks
	// ****************************************
	property p_dir_input_tristate;
		@(posedge clk_i) disable iff (rst_i)
		(dir_reg[3] && !capture_compare_unit_4_io_out_en_i) |-> pin_oe_n_o[3];
	endproperty
	a_dir_input_tristate: assert property (p_dir_input_tristate)
		else $error("input pin 3 is being driven");

	property p_latch_drives;
		@(posedge clk_i) disable iff (rst_i)
		(!dir_reg[4] && !capture_compare_unit_5_io_out_en_i && !pwm1d_en_i) |->
			(!pin_oe_n_o[4] && pin_o[4] == lat_reg[4]);
	endproperty
	a_latch_drives: assert property (p_latch_drives)
		else $error("pin 4 does not drive latch");

	property p_latch_write;
		@(posedge clk_i) disable iff (rst_i)
		latch_wr_i |=> output_latch_register_o[4:0] == $past(wdata_i[4:0]);
	endproperty
	a_latch_write: assert property (p_latch_write)
		else $error("latch write not stored");

	property p_dir_stable;
		@(posedge clk_i) disable iff (rst_i)
		!dir_wr_i |=> $stable(direction_register_o);
	endproperty
	a_dir_stable: assert property (p_dir_stable)
		else $error("direction changed without a write");

	property p_pin5_gate;
		@(posedge clk_i) disable iff (rst_i)
		reset_pin_config_bit_i |-> !port_pin_register_o[5];
	endproperty
	a_pin5_gate: assert property (p_pin5_gate)
		else $error("port bit 5 visible in master-clear mode");

	property p_capture_compare_unit_4_io_priority;
		@(posedge clk_i) disable iff (rst_i)
		(capture_compare_unit_4_io_out_en_i && !dir_reg[3]) |-> (pin_o[3] == capture_compare_unit_4_io_out_i && !pin_oe_n_o[3]);
	endproperty
	a_capture_compare_unit_4_io_priority: assert property (p_capture_compare_unit_4_io_priority)
		else $error("unit 4 output lost priority");

	property p_pwm1d_tri;
		@(posedge clk_i) disable iff (rst_i)
		(pwm1d_en_i && pwm1d_tri_i && !capture_compare_unit_5_io_out_en_i) |-> pin_oe_n_o[4];
	endproperty
	a_pwm1d_tri: assert property (p_pwm1d_tri)
		else $error("pin 4 not tri-stated at shutdown");

	property p_port_write;
		@(posedge clk_i) disable iff (rst_i)
		(port_wr_i && !latch_wr_i) |=> lat_reg == $past(wdata_i[4:0]);
	endproperty
	a_port_write: assert property (p_port_write)
		else $error("port write missed latch");

	property p_reserved_zero;
		@(posedge clk_i) disable iff (rst_i)
		port_pin_register_o[7:6] == 2'h0 && direction_register_o[7:5] == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("unimplemented bits not zero");

	property p_pin0_capture_compare_unit_3_io;
		@(posedge clk_i) disable iff (rst_i)
		(capture_compare_unit_3_io_out_en_i && !dir_reg[0]) |-> (pin_o[0] == capture_compare_unit_3_io_out_i && !pin_oe_n_o[0]);
	endproperty
	a_pin0_capture_compare_unit_3_io: assert property (p_pin0_capture_compare_unit_3_io)
		else $error("unit 3 output lost pin 0");

	property p_pin0_pwm3a;
		@(posedge clk_i) disable iff (rst_i)
		(pwm3a_en_i && !capture_compare_unit_3_io_out_en_i && !dir_reg[0]) |-> pin_oe_n_o[0] == pwm3a_tri_i;
	endproperty
	a_pin0_pwm3a: assert property (p_pin0_pwm3a)
		else $error("pin 0 shutdown tri-state wrong");

	// Pin 0 with no peripheral must fall back to the latch
	property p_pin0_latch;
		@(posedge clk_i) disable iff (rst_i)
		(!dir_reg[0] && !capture_compare_unit_3_io_out_en_i && !pwm3a_en_i) |->
			(!pin_oe_n_o[0] && pin_o[0] == lat_reg[0]);
	endproperty
	a_pin0_latch: assert property (p_pin0_latch)
		else $error("pin 0 does not fall back to latch");

	property p_pin1_tx;
		@(posedge clk_i) disable iff (rst_i)
		(ser_tx_en_i && !ser_sync_i && !dir_reg[1]) |->
			(pin_o[1] == ser_tx_i && !pin_oe_n_o[1]);
	endproperty
	a_pin1_tx: assert property (p_pin1_tx)
		else $error("transmit data not on pin 1");

	property p_pin1_clock;
		@(posedge clk_i) disable iff (rst_i)
		(ser_tx_en_i && ser_sync_i && !dir_reg[1]) |->
			(pin_o[1] == ser_ck_out_i && !pin_oe_n_o[1]);
	endproperty
	a_pin1_clock: assert property (p_pin1_clock)
		else $error("sync clock not on pin 1");

	// Sync data must drive although software keeps the direction bit at one
	property p_pin2_sync_drive;
		@(posedge clk_i) disable iff (rst_i)
		(ser_sync_i && ser_dt_drive_i) |-> (pin_o[2] == ser_dt_out_i && !pin_oe_n_o[2]);
	endproperty
	a_pin2_sync_drive: assert property (p_pin2_sync_drive)
		else $error("sync data not on pin 2");

	property p_pin3_pwm3d;
		@(posedge clk_i) disable iff (rst_i)
		(pwm3d_en_i && !capture_compare_unit_4_io_out_en_i && !dir_reg[3]) |-> pin_oe_n_o[3] == pwm3d_tri_i;
	endproperty
	a_pin3_pwm3d: assert property (p_pin3_pwm3d)
		else $error("pin 3 shutdown tri-state wrong");

	property p_pin4_capture_compare_unit_5_io;
		@(posedge clk_i) disable iff (rst_i)
		(capture_compare_unit_5_io_out_en_i && !dir_reg[4]) |-> (pin_o[4] == capture_compare_unit_5_io_out_i && !pin_oe_n_o[4]);
	endproperty
	a_pin4_capture_compare_unit_5_io: assert property (p_pin4_capture_compare_unit_5_io)
		else $error("unit 5 output lost priority");

	property p_pin5_port;
		@(posedge clk_i) disable iff (rst_i)
		!reset_pin_config_bit_i |->
			(port_pin_register_o[5] == pin_i[5] && master_clear_input_n_o);
	endproperty
	a_pin5_port: assert property (p_pin5_port)
		else $error("pin 5 not a plain input");

	property p_master_clear_input_follow;
		@(posedge clk_i) disable iff (rst_i)
		reset_pin_config_bit_i |-> master_clear_input_n_o == pin_i[5];
	endproperty
	a_master_clear_input_follow: assert property (p_master_clear_input_follow)
		else $error("master clear does not follow pin 5");

	// Checked one edge into reset, so the asynchronous clear has landed
	property p_reset_values;
		@(posedge clk_i)
		(rst_i ##1 rst_i) |-> (direction_register_o[4:0] == `SBP_DIR_RST &&
			output_latch_register_o[4:0] == `SBP_LAT_RST);
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("reset did not make all pins inputs");

endmodule

// ==== bench/sbp_pin_world.sv ====
// Far side of the port: pin wires with external drivers and peripheral levels.
// Assumes the port drives a pin while its enable is low; ext_i drives the rest.
module sbp_pin_world
	import sbp_pkg::*;
(
	// Port drive
	input  wire logic [4:0] pin_o,
	input  wire logic [4:0] pin_oe_n_o,
	// External levels, pin 5 always external
	input  wire logic [5:0] ext_i,
	output logic      [5:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// A released pin shows the outside level, never the stale drive
	always_comb begin
		pin_i[5] = ext_i[5];
		for (int k = 0; k < 5; k++) begin
			pin_i[k] = pin_oe_n_o[k] ? ext_i[k] : pin_o[k];
		end
	end
endmodule

// ==== bench/sbp_port_test.sv ====
// Self-checking bench for the six-bit port with peripheral overrides.
// Assumes the pin world model and the design files are compiled first.
module sbp_port_test
	import sbp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk_i, rst_i, port_wr_i, latch_wr_i, dir_wr_i, cfg;
	sbp_byte_t  wdata_i, port_q, latch_q, dir_q;
	logic [5:0] ext, pin_i;
	logic [4:0] pin_o, oe_n;
	logic       master_clear_input_n, cap3, cap4, cap5, ck_in, rx;
	// Peripheral outputs, see the instance for the bit order
	logic [20:0] pv;
	int         n_errors, n_compared;

	sbp_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .port_wr_i(port_wr_i),
		.latch_wr_i(latch_wr_i), .dir_wr_i(dir_wr_i), .wdata_i(wdata_i),
		.port_pin_register_o(port_q), .output_latch_register_o(latch_q),
		.direction_register_o(dir_q), .reset_pin_config_bit_i(cfg),
		.master_clear_input_n_o(master_clear_input_n), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n),
		.capture_compare_unit_3_io_out_en_i(pv[0]), .capture_compare_unit_3_io_out_i(pv[1]), .pwm3a_en_i(pv[2]), .pwm3a_out_i(pv[3]),
		.pwm3a_tri_i(pv[4]), .capture_compare_unit_3_io_capture_o(cap3), .ser_tx_en_i(pv[5]), .ser_tx_i(pv[6]),
		.ser_sync_i(pv[7]), .ser_ck_out_i(pv[8]), .ser_dt_drive_i(pv[9]),
		.ser_dt_out_i(pv[10]), .ser_ck_in_o(ck_in), .ser_rx_o(rx),
		.capture_compare_unit_4_io_out_en_i(pv[11]), .capture_compare_unit_4_io_out_i(pv[12]), .pwm3d_en_i(pv[13]),
		.pwm3d_out_i(pv[14]), .pwm3d_tri_i(pv[15]), .capture_compare_unit_4_io_capture_o(cap4),
		.capture_compare_unit_5_io_out_en_i(pv[16]), .capture_compare_unit_5_io_out_i(pv[17]), .pwm1d_en_i(pv[18]),
		.pwm1d_out_i(pv[19]), .pwm1d_tri_i(pv[20]), .capture_compare_unit_5_io_capture_o(cap5));

	sbp_pin_world world_u (.pin_o(pin_o), .pin_oe_n_o(oe_n), .ext_i(ext), .pin_i(pin_i));

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic go;
		@(posedge clk_i);
		#1;
	endtask

	// Strobe order {dir, latch, port}, one pulse per write
	task automatic wr(input logic [2:0] s, input sbp_byte_t d);
		go();
		{dir_wr_i, latch_wr_i, port_wr_i} = s;
		wdata_i = d;
		go();
		{dir_wr_i, latch_wr_i, port_wr_i} = 3'h0;
	endtask

	task automatic chk(input sbp_byte_t got, input sbp_byte_t exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// Guard against a hung sequence
	initial begin
		#200000;
		n_errors++;
		conclude();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{rst_i, port_wr_i, latch_wr_i, dir_wr_i, cfg} = 5'h10;
		{wdata_i, ext, pv} = '0;
		n_errors = 0;
		n_compared = 0;
		repeat (6) go();
		rst_i = 1'b0;
		chk(dir_q, 8'h1F);
		chk(latch_q, 8'h00);
		chk({3'h0, oe_n}, 8'h1F);
		$display("test reset done");
		ext = 6'h3F;
		wr(3'h4, 8'hE0);
		wr(3'h2, 8'hF5);
		chk(dir_q, 8'h00);
		chk(latch_q, 8'h15);
		chk({3'h0, pin_o}, 8'h15);
		chk({3'h0, oe_n}, 8'h00);
		chk(port_q, 8'h35);
		ext = 6'h2A;
		wr(3'h1, 8'h0A);
		wr(3'h4, 8'hFF);
		chk(latch_q, 8'h0A);
		chk({3'h0, oe_n}, 8'h1F);
		chk(port_q, 8'h2A);
		cfg = 1'b1;
		go();
		chk(port_q, 8'h0A);
		chk({7'h0, master_clear_input_n}, 8'h01);
		ext = 6'h0A;
		go();
		chk({7'h0, master_clear_input_n}, 8'h00);
		$display("test registers done");
		cfg = 1'b0;
		ext = 6'h00;
		wr(3'h6, 8'h00);
		pv = 21'h0B3867;
		go();
		chk({3'h0, pin_o}, 8'h1B);
		chk({3'h0, oe_n}, 8'h00);
		chk(dir_q, 8'h00);
		wr(3'h2, 8'h1F);
		pv = 21'h04A0A4;
		go();
		chk({3'h0, pin_o & 5'h17}, 8'h04);
		chk({3'h0, oe_n}, 8'h08);
		// Shutdown tri-state on pins 0 and 4 as well
		pv = 21'h14A0B4;
		go();
		chk({3'h0, oe_n}, 8'h19);
		$display("test overrides done");
		wr(3'h4, 8'h1F);
		ext = 6'h15;
		pv = 21'h000280;
		go();
		chk({3'h0, oe_n}, 8'h1B);
		chk({3'h0, pin_o & 5'h04}, 8'h00);
		chk({4'h0, cap5, cap4, ck_in, cap3}, 8'h09);
		chk({7'h0, rx}, 8'h00);
		pv = '0;
		go();
		chk({7'h0, rx}, 8'h01);
		chk({3'h0, oe_n}, 8'h1F);
		$display("test inputs done");
		// Second reset in mid-run must undo direction and latch writes
		wr(3'h4, 8'h00);
		rst_i = 1'b1;
		go();
		go();
		rst_i = 1'b0;
		chk(dir_q, 8'h1F);
		chk(latch_q, 8'h00);
		chk({3'h0, oe_n}, 8'h1F);
		$display("test mid-run reset done");
		conclude();
	end
endmodule
